//--- hw/sfc_ctrl.sv
/*
 * Serial flash controller configuration block: Avalon-MM register slave,
 * serial master shifter with bit-order, byte-order and MOSI fill options,
 * state view, supply gating and bypass.
 * Assumes the sequencer feeding op_* and the FIFO and memory master state
 * inputs run on mclk_i; MISO and the select feedback come from pins.
 */
`timescale 1ns/1ps
module sfc_ctrl
	import sfc_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// avalon-mm register slave
	input wire logic [31:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// operation request from the sequencer
	input wire logic op_valid_i,
	input wire sfc_pkg::sfc_op_t op_kind_i,
	input wire logic [31:0] op_data_i,
	input wire logic op_last_i,
	output logic op_ready_o,
	// received word towards buffers
	output logic rsp_valid_o,
	output sfc_pkg::sfc_op_t rsp_kind_o,
	output logic [31:0] rsp_data_o,
	// other state machines of the controller
	input wire logic [2:0] fifo_state_i,
	input wire logic [1:0] mem_state_i,
	// serial flash pins
	output logic sck_o,
	output logic mosi_o,
	input wire logic miso_i,
	output logic slave_select_line_n_o,
	input wire logic slave_select_line_n_i,
	// system side controls
	output logic flash_supply_en_o,
	output logic bypass_o,
	output logic [31:0] buffer_base_o
);
	// ****************************************************************
	// registers
	// ****************************************************************
	logic [7:0] flash_supply_enable;
	logic [7:0] flash_controller_bypass;
	logic [31:0] buffer_base_pointer;
	logic [15:0] bit_order_options;
	logic [15:0] receive_phase_line_control;
	logic [15:0] fsm_state_view;

	logic bus_req;
	logic bus_commit_wr;
	logic [31:0] rd_mux;
	logic [31:0] be_mask;
	logic [31:0] wr_masked;

	// ****************************************************************
	// serial engine state
	// ****************************************************************
	sfc_spi_state_t state;
	sfc_op_t cur_kind;
	logic cur_last;
	logic [31:0] tx_sh;
	logic [31:0] rx_sh;
	logic [5:0] bit_idx;
	logic [5:0] nbits;
	logic [2:0] div_cnt;
	logic accept;
	logic half_done;
	logic last_bit;
	logic is_read_kind;
	logic [1:0] pin_sync;
	logic miso_s;
	logic select_sync_view;
	logic [2:0] fifo_state_q;
	logic [1:0] mem_state_q;

	logic [31:0] tx_word_ordered;
	logic [31:0] tx_word_flipped;
	logic [7:0] tx_cmd_flipped;
	logic [31:0] next_tx;
	logic [5:0] next_nbits;
	logic [31:0] rx_ordered;
	logic [31:0] rx_flipped;
	logic rx_flip_en;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	sfc_sync2 #(
		.W(2),
		.RST_VAL(2'h0)
	) u_pin_sync (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.d_i({slave_select_line_n_i, miso_i}),
		.q_o(pin_sync)
	);
	assign miso_s = pin_sync[0];
	assign select_sync_view = pin_sync[1];

	// ****************************************************************
	// avalon-mm slave
	// ****************************************************************
	// waitrequest idles high; one cycle after a request it drops for one
	// cycle, the edge where the master samples it low commits the access
	assign bus_req = read_i || write_i;
	assign bus_commit_wr = write_i && !waitrequest_o;

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			waitrequest_o <= 1'b1;
		end else begin
			waitrequest_o <= !(bus_req && waitrequest_o);
		end
	end

	always_comb begin
		rd_mux = SFC_READ_UNMAPPED;
		case (address_i)
			SFC_ADDR_SUPPLY: rd_mux = {24'h000000, flash_supply_enable};
			SFC_ADDR_BYPASS: rd_mux = {24'h000000, flash_controller_bypass};
			SFC_ADDR_BASE_PTR: rd_mux = buffer_base_pointer;
			SFC_ADDR_BIT_ORDER: rd_mux = {16'h0000, bit_order_options};
			SFC_ADDR_LINE_CTRL: rd_mux = {16'h0000, receive_phase_line_control};
			SFC_ADDR_FSM_VIEW: rd_mux = {16'h0000, fsm_state_view};
			default: rd_mux = SFC_READ_UNMAPPED;
		endcase
	end

	// read data is captured one edge before the committing edge and stands there
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			readdata_o <= 32'h00000000;
		end else if (read_i && waitrequest_o) begin
			readdata_o <= rd_mux;
		end
	end

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			be_mask[8*b +: 8] = byteenable_i[b] ? 8'hFF : 8'h00;
		end
	end

	// ****************************************************************
	// register writes
	// ****************************************************************
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			flash_supply_enable <= SFC_SUPPLY_RST;
			flash_controller_bypass <= SFC_BYPASS_RST;
		end else if (bus_commit_wr && byteenable_i[0]) begin
			if (address_i == SFC_ADDR_SUPPLY) begin
				flash_supply_enable <= {7'h00, writedata_i[0]};
			end
			if (address_i == SFC_ADDR_BYPASS) begin
				flash_controller_bypass <= {7'h00, writedata_i[0]};
			end
		end
	end

	assign wr_masked = writedata_i & be_mask;

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			buffer_base_pointer <= SFC_BASE_PTR_RST;
		end else if (bus_commit_wr && address_i == SFC_ADDR_BASE_PTR) begin
			buffer_base_pointer <= wr_masked | (buffer_base_pointer & ~be_mask);
		end
	end

	// option bits are stored masked by SFC_BIT_ORDER_MASK and SFC_LINE_CTRL_MASK; other bits read zero
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			bit_order_options <= SFC_BIT_ORDER_RST;
			receive_phase_line_control <= SFC_LINE_CTRL_RST;
		end else if (bus_commit_wr) begin
			if (address_i == SFC_ADDR_BIT_ORDER) begin
				bit_order_options <= (wr_masked[15:0] | (bit_order_options & ~be_mask[15:0]))
					& SFC_BIT_ORDER_MASK;
			end
			if (address_i == SFC_ADDR_LINE_CTRL) begin
				receive_phase_line_control <= (wr_masked[15:0]
					| (receive_phase_line_control & ~be_mask[15:0]))
					& SFC_LINE_CTRL_MASK;
			end
		end
	end

	// ****************************************************************
	// state view, writes never reach it
	// ****************************************************************
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			fifo_state_q <= 3'h0;
			mem_state_q <= 2'h0;
		end else begin
			fifo_state_q <= fifo_state_i;
			mem_state_q <= mem_state_i;
		end
	end

	always_comb begin
		fsm_state_view = 16'h0000;
		fsm_state_view[SFC_FV_SELECT] = select_sync_view;
		fsm_state_view[SFC_FV_SPI_LSB +: 3] = state;
		fsm_state_view[SFC_FV_FIFO_LSB +: 3] = fifo_state_q;
		fsm_state_view[SFC_FV_MEM_LSB +: 2] = mem_state_q;
	end

	// ****************************************************************
	// system side outputs
	// ****************************************************************
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			flash_supply_en_o <= SFC_SUPPLY_RST[0];
			bypass_o <= SFC_BYPASS_RST[0];
			buffer_base_o <= SFC_BASE_PTR_RST;
		end else begin
			flash_supply_en_o <= flash_supply_enable[0];
			bypass_o <= flash_controller_bypass[0];
			buffer_base_o <= buffer_base_pointer;
		end
	end

	// ****************************************************************
	// transmit word preparation
	// ****************************************************************
	// little-endian sends byte 0 first; the shifter always emits bit 31 first
	assign tx_word_ordered = bit_order_options[SFC_BO_BYTE_ORDER]
		? {op_data_i[7:0], op_data_i[15:8], op_data_i[23:16], op_data_i[31:24]}
		: op_data_i;

	sfc_byte_flip #(
		.NBYTES(4)
	) u_flip_wdata (
		.en_i(bit_order_options[SFC_BO_WDATA_REV]),
		.d_i(tx_word_ordered),
		.q_o(tx_word_flipped)
	);

	sfc_byte_flip #(
		.NBYTES(1)
	) u_flip_cmd (
		.en_i(bit_order_options[SFC_BO_CMD_REV]),
		.d_i(op_data_i[7:0]),
		.q_o(tx_cmd_flipped)
	);

	always_comb begin
		next_tx = 32'h00000000;
		next_nbits = SFC_BYTE_BITS;
		case (op_kind_i)
			SFC_OP_CMD: next_tx = {tx_cmd_flipped, 24'h000000};
			SFC_OP_WDATA: begin
				next_tx = tx_word_flipped;
				next_nbits = SFC_WORD_BITS;
			end
			SFC_OP_RDATA: next_nbits = SFC_WORD_BITS;
			SFC_OP_STATUS: next_nbits = SFC_BYTE_BITS;
			default: next_tx = 32'h00000000;
		endcase
	end

	// ****************************************************************
	// receive phase line value
	// ****************************************************************
	// several options set: filler wins, then toggle, drive-high, drive-low
	function automatic logic fill_bit(input logic [5:0] idx, input logic [15:0] lc);
		logic v;
		v = 1'b0;
		if (lc[SFC_LC_FILL_ON]) begin
			v = lc[SFC_LC_FILL_LSB + 7 - int'(idx[2:0])];
		end else if (lc[SFC_LC_TOGGLE]) begin
			v = !idx[0];
		end else if (lc[SFC_LC_DRIVE1]) begin
			v = 1'b1;
		end else if (lc[SFC_LC_DRIVE0]) begin
			v = 1'b0;
		end
		return v;
	endfunction

	assign is_read_kind = (cur_kind == SFC_OP_RDATA) || (cur_kind == SFC_OP_STATUS);
	assign accept = op_valid_i && op_ready_o;
	assign half_done = (div_cnt == 3'(SFC_SCK_HALF_CYC - 1));
	assign last_bit = (bit_idx == nbits - 6'h01);

	// ****************************************************************
	// serial master state machine
	// ****************************************************************
	// mode 0: mosi changes with sck low, miso is taken at the end of the
	// high phase so the two synchroniser stages have settled
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			state <= SFC_ST_IDLE;
			cur_kind <= SFC_OP_CMD;
			cur_last <= 1'b0;
			tx_sh <= 32'h00000000;
			rx_sh <= 32'h00000000;
			bit_idx <= 6'h00;
			nbits <= SFC_BYTE_BITS;
			div_cnt <= 3'h0;
			sck_o <= 1'b0;
			mosi_o <= 1'b0;
			slave_select_line_n_o <= 1'b1;
			op_ready_o <= 1'b0;
		end else begin
			case (state)
				SFC_ST_IDLE, SFC_ST_HOLD: begin
					op_ready_o <= !flash_controller_bypass[0] && !accept;
					if (accept) begin
						state <= SFC_ST_SHIFT;
						cur_kind <= op_kind_i;
						cur_last <= op_last_i;
						tx_sh <= next_tx;
						nbits <= next_nbits;
						bit_idx <= 6'h00;
						div_cnt <= 3'h0;
						sck_o <= 1'b0;
						slave_select_line_n_o <= 1'b0;
						if (op_kind_i == SFC_OP_RDATA || op_kind_i == SFC_OP_STATUS) begin
							mosi_o <= fill_bit(6'h00, receive_phase_line_control);
						end else begin
							mosi_o <= next_tx[31];
						end
					end else if (state == SFC_ST_HOLD && flash_controller_bypass[0]) begin
						state <= SFC_ST_DESEL;
						div_cnt <= 3'h0;
						slave_select_line_n_o <= 1'b1;
					end
				end
				SFC_ST_SHIFT: begin
					div_cnt <= half_done ? 3'h0 : div_cnt + 3'h1;
					if (half_done && !sck_o) begin
						sck_o <= 1'b1;
					end else if (half_done) begin
						sck_o <= 1'b0;
						rx_sh <= {rx_sh[30:0], miso_s};
						tx_sh <= {tx_sh[30:0], 1'b0};
						if (last_bit) begin
							if (cur_last) begin
								state <= SFC_ST_DESEL;
								slave_select_line_n_o <= 1'b1;
							end else begin
								state <= SFC_ST_HOLD;
								op_ready_o <= !flash_controller_bypass[0];
							end
						end else begin
							bit_idx <= bit_idx + 6'h01;
							mosi_o <= is_read_kind
								? fill_bit(bit_idx + 6'h01, receive_phase_line_control)
								: tx_sh[30];
						end
					end
				end
				SFC_ST_DESEL: begin
					// keeps select high for a half period before the next frame
					div_cnt <= half_done ? 3'h0 : div_cnt + 3'h1;
					mosi_o <= 1'b0;
					if (half_done) begin
						state <= SFC_ST_IDLE;
						op_ready_o <= !flash_controller_bypass[0];
					end
				end
				default: begin
					state <= SFC_ST_IDLE;
					slave_select_line_n_o <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************************************
	// receive word handling
	// ****************************************************************
	assign rx_ordered = bit_order_options[SFC_BO_BYTE_ORDER]
		? {rx_sh[7:0], rx_sh[15:8], rx_sh[23:16], rx_sh[31:24]}
		: rx_sh;
	assign rx_flip_en = (cur_kind == SFC_OP_STATUS)
		? bit_order_options[SFC_BO_STATUS_FLIP]
		: bit_order_options[SFC_BO_RDATA_REV];

	sfc_byte_flip #(
		.NBYTES(4)
	) u_flip_rx (
		.en_i(rx_flip_en),
		.d_i((cur_kind == SFC_OP_STATUS) ? rx_sh : rx_ordered),
		.q_o(rx_flipped)
	);

	// the last miso bit enters rx_sh on the final sample edge, so the word is
	// taken one edge later; cur_kind cannot change before that edge
	logic rsp_pend;

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			rsp_pend <= 1'b0;
		end else begin
			rsp_pend <= state == SFC_ST_SHIFT && half_done && sck_o && last_bit && is_read_kind;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_kind_o <= SFC_OP_CMD;
			rsp_data_o <= 32'h00000000;
		end else begin
			rsp_valid_o <= 1'b0;
			if (rsp_pend) begin
				rsp_valid_o <= 1'b1;
				rsp_kind_o <= cur_kind;
				rsp_data_o <= (cur_kind == SFC_OP_STATUS)
					? {24'h000000, rx_flipped[7:0]} : rx_flipped;
			end
		end
	end
endmodule // sfc_ctrl

//--- hw/sfc_pkg.sv
/*
 * Shared constants and types of the serial flash controller configuration block.
 * Operation list, register byte addresses, field positions, reset values,
 * serial clock timing and the serial master state encoding.
 * Assumes a 100 MHz system clock and a 32-bit byte-addressed register bus.
 */
package sfc_pkg;

	// ****************************************************************
	// register byte addresses
	// ****************************************************************
	localparam logic [31:0] SFC_ADDR_SUPPLY = 32'h4000B0A0;
	localparam logic [31:0] SFC_ADDR_BYPASS = 32'h4000B0A4;
	localparam logic [31:0] SFC_ADDR_BASE_PTR = 32'h4001201C;
	localparam logic [31:0] SFC_ADDR_BIT_ORDER = 32'h40012020;
	localparam logic [31:0] SFC_ADDR_LINE_CTRL = 32'h40012024;
	localparam logic [31:0] SFC_ADDR_FSM_VIEW = 32'h40012028;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] SFC_SUPPLY_RST = 8'h01;
	localparam logic [7:0] SFC_BYPASS_RST = 8'h00;
	localparam logic [31:0] SFC_BASE_PTR_RST = 32'h00000000;
	localparam logic [15:0] SFC_BIT_ORDER_RST = 16'h0103;
	localparam logic [15:0] SFC_LINE_CTRL_RST = 16'h0000;
	localparam logic [31:0] SFC_READ_UNMAPPED = 32'h00000000;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int SFC_BO_WDATA_REV = 8;
	localparam int SFC_BO_STATUS_FLIP = 3;
	localparam int SFC_BO_RDATA_REV = 2;
	localparam int SFC_BO_CMD_REV = 1;
	localparam int SFC_BO_BYTE_ORDER = 0;
	localparam logic [15:0] SFC_BIT_ORDER_MASK = 16'h01FF;
	localparam int SFC_LC_FILL_LSB = 8;
	localparam int SFC_LC_FILL_ON = 3;
	localparam int SFC_LC_TOGGLE = 2;
	localparam int SFC_LC_DRIVE1 = 1;
	localparam int SFC_LC_DRIVE0 = 0;
	localparam logic [15:0] SFC_LINE_CTRL_MASK = 16'hFF0F;
	localparam int SFC_FV_SELECT = 12;
	localparam int SFC_FV_SPI_LSB = 8;
	localparam int SFC_FV_FIFO_LSB = 4;
	localparam int SFC_FV_MEM_LSB = 0;

	// ****************************************************************
	// serial timing
	// ****************************************************************
	localparam int SFC_CLK_MHZ = 100;
	localparam int SFC_SCK_HALF_NS = 40;
	localparam int SFC_SCK_HALF_CYC = (SFC_SCK_HALF_NS * SFC_CLK_MHZ + 999) / 1000;
	localparam logic [5:0] SFC_BYTE_BITS = 6'h08;
	localparam logic [5:0] SFC_WORD_BITS = 6'h20;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		SFC_ST_IDLE = 3'h0,
		SFC_ST_SHIFT = 3'h1,
		SFC_ST_HOLD = 3'h3,
		SFC_ST_DESEL = 3'h2
	} sfc_spi_state_t;

	typedef enum logic [1:0] {
		SFC_OP_CMD = 2'h0,
		SFC_OP_WDATA = 2'h1,
		SFC_OP_RDATA = 2'h2,
		SFC_OP_STATUS = 2'h3
	} sfc_op_t;

endpackage

//--- hw/sfc_sync2.sv
/*
 * Two-stage level synchroniser with a constant reset value.
 * Assumes inputs are levels that stay stable for several system clocks.
 */
`timescale 1ns/1ps
module sfc_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	// the first stage is read only by the second
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			meta <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // sfc_sync2

//--- hw/sfc_byte_flip.sv
/*
 * Reverses the bit order inside every byte of a word when enabled.
 * Purely combinational; assumes the width is a whole number of bytes.
 */
`timescale 1ns/1ps
module sfc_byte_flip #(
	parameter int NBYTES = 4
) (
	// control
	input wire logic en_i,
	// data
	input wire logic [8*NBYTES-1:0] d_i,
	output logic [8*NBYTES-1:0] q_o
);
	genvar b, i;
	generate
		for (b = 0; b < NBYTES; b++) begin : g_byte
			for (i = 0; i < 8; i++) begin : g_bit
				assign q_o[8*b+i] = en_i ? d_i[8*b+7-i] : d_i[8*b+i];
			end
		end
	endgenerate
endmodule // sfc_byte_flip

//--- sim/sfc_chk.sv
/* checker: bus handshake, register side effects and mosi line rules of sfc_ctrl.
 * sees only top ports; shadows two registers from committed bus writes. */
`timescale 1ns/1ps
module sfc_chk
	import sfc_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [31:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [31:0] readdata_o,
	input wire logic waitrequest_o,
	input wire logic op_valid_i,
	input wire sfc_pkg::sfc_op_t op_kind_i,
	input wire logic [31:0] op_data_i,
	input wire logic op_ready_o,
	input wire logic mosi_o,
	input wire logic flash_supply_en_o,
	input wire logic bypass_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	logic [15:0] bo;
	logic [15:0] lc;
	logic wr_go;
	logic wfb;
	logic cfb;
	assign wr_go = write_i && !waitrequest_o;
	assign wfb = bo[0] ? op_data_i[bo[8] ? 0 : 7] : op_data_i[bo[8] ? 24 : 31];
	assign cfb = op_data_i[bo[1] ? 0 : 7];
	// shadows let the line checks know the mode without peeking inside
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			bo <= SFC_BIT_ORDER_RST;
			lc <= SFC_LINE_CTRL_RST;
		end else if (wr_go && address_i == SFC_ADDR_BIT_ORDER) begin
			bo <= writedata_i[15:0] & SFC_BIT_ORDER_MASK;
		end else if (wr_go && address_i == SFC_ADDR_LINE_CTRL) begin
			lc <= writedata_i[15:0] & SFC_LINE_CTRL_MASK;
		end
	end
	sequence s_take(k, m);
		op_valid_i && op_ready_o && op_kind_i == k && m;
	endsequence
	wait_resp_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("no bus answer one cycle after request");
	supply_wr_a: assert property (
		wr_go && address_i == SFC_ADDR_SUPPLY |-> ##2 flash_supply_en_o == $past(writedata_i[0], 2))
		else $error("supply enable does not follow write");
	view_rsvd_a: assert property (
		read_i && !waitrequest_o && address_i == SFC_ADDR_FSM_VIEW |-> (readdata_o & 32'hFFFFE88C) == 32'h0)
		else $error("reserved state view bits not zero");
	bypass_hold_a: assert property (bypass_o && $past(bypass_o) |-> !op_ready_o)
		else $error("operation offered while bypassed");
	wfirst_bit_a: assert property (s_take(SFC_OP_WDATA, 1'b1) |=> mosi_o == $past(wfb))
		else $error("wrong first data bit");
	cfirst_bit_a: assert property (s_take(SFC_OP_CMD, 1'b1) |=> mosi_o == $past(cfb))
		else $error("wrong first command bit");
	drive_hi_a: assert property (s_take(SFC_OP_RDATA, lc[3:0] == 4'h2) |=> mosi_o [*8])
		else $error("mosi not high while receiving");
	drive_lo_a: assert property (s_take(SFC_OP_RDATA, lc[3:0] == 4'h1) |=> !mosi_o [*8])
		else $error("mosi not low while receiving");
	toggle_a: assert property (
		s_take(SFC_OP_RDATA, lc[3:0] == 4'h4) |=> mosi_o [*8] ##1 !mosi_o [*8])
		else $error("mosi does not alternate while receiving");
endmodule // sfc_chk

//--- sim/sfc_flash_model.sv
/* serial flash model: answers with a preset word msb first and keeps the
 * last 32 bits seen on mosi. assumes sck idles low, select active low. */
`timescale 1ns/1ps
module sfc_flash_model (
	input wire logic sck_i,
	input wire logic sel_n_i,
	input wire logic mosi_i,
	input wire logic [31:0] tx_word_i,
	output logic miso_o,
	output logic [31:0] rx_word_o
);
	logic [31:0] tx_sh = 32'h0;
	initial miso_o = 1'b0;
	initial rx_word_o = 32'h0;
	always @(negedge sel_n_i) tx_sh = tx_word_i;
	// data moves on the rising edge so the falling-edge sample sees it settled
	always @(posedge sck_i) begin
		if (!sel_n_i) begin
			rx_word_o <= {rx_word_o[30:0], mosi_i};
			miso_o <= tx_sh[31];
			tx_sh <= {tx_sh[30:0], 1'b0};
		end
	end
	// a released line holds no value: show the inverse of the last bit
	always @(posedge sel_n_i) miso_o <= ~miso_o;
endmodule // sfc_flash_model

//--- sim/tb_sfc_ctrl.sv
/* bench for sfc_ctrl: register table over avalon, then frames against the
 * flash model. assumes a 100 MHz clock and the model on the serial pins. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_sfc_ctrl;
	import sfc_pkg::*;
	typedef struct {logic [31:0] a; logic w; logic [31:0] d; logic [31:0] e;} sfc_tb_row_t;
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [31:0] address_i = 32'h0;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic [31:0] readdata_o;
	logic waitrequest_o;
	logic op_valid_i = 1'b0;
	sfc_op_t op_kind_i = SFC_OP_CMD;
	logic [31:0] op_data_i = 32'h0;
	logic op_last_i = 1'b0;
	logic op_ready_o, rsp_valid_o, sck_o, mosi_o, miso_i, sel_n, flash_supply_en_o, bypass_o;
	sfc_op_t rsp_kind_o, rsp_k;
	logic [31:0] rsp_data_o, buffer_base_o, rx_word, rsp_q;
	logic [2:0] fifo_state_i = 3'h0;
	logic [1:0] mem_state_i = 2'h0;
	int fail_count = 0;
	int samples_checked = 0;
	sfc_tb_row_t rows [12] = '{'{SFC_ADDR_SUPPLY, 1'b0, 32'h0, 32'h1},
		'{SFC_ADDR_BYPASS, 1'b0, 32'h0, 32'h0}, '{SFC_ADDR_BIT_ORDER, 1'b0, 32'h0, 32'h103},
		'{SFC_ADDR_LINE_CTRL, 1'b0, 32'h0, 32'h0}, '{SFC_ADDR_FSM_VIEW, 1'b0, 32'h0, 32'h1000},
		'{SFC_ADDR_BASE_PTR, 1'b1, 32'hA55A3CC3, 32'hA55A3CC3},
		'{SFC_ADDR_BIT_ORDER, 1'b1, 32'hFFFFFE0F, 32'h00F},
		'{SFC_ADDR_LINE_CTRL, 1'b1, 32'hFFFFFFFF, 32'hFF0F},
		'{SFC_ADDR_FSM_VIEW, 1'b1, 32'hFFFF, 32'h1000}, '{32'h4001202C, 1'b1, 32'hFFFF, 32'h0},
		'{SFC_ADDR_SUPPLY, 1'b1, 32'h0, 32'h0}, '{SFC_ADDR_SUPPLY, 1'b1, 32'h1, 32'h1}};
	logic [47:0] modes [6] = '{48'h3C083C3C3C3C, 48'h0004AAAAAAAA, 48'h0002FFFFFFFF,
		48'h000100000000, 48'h3C0F3C3C3C3C, 48'h000000000000};
	sfc_ctrl i_sfc_ctrl (.mclk_i, .nrst_i, .address_i, .read_i, .write_i, .byteenable_i(4'hF),
		.writedata_i, .readdata_o, .waitrequest_o, .op_valid_i, .op_kind_i, .op_data_i,
		.op_last_i, .op_ready_o, .rsp_valid_o, .rsp_kind_o, .rsp_data_o, .fifo_state_i,
		.mem_state_i, .sck_o, .mosi_o, .miso_i, .slave_select_line_n_o(sel_n),
		.slave_select_line_n_i(sel_n), .flash_supply_en_o, .bypass_o, .buffer_base_o);
	sfc_flash_model i_sfc_flash_model (.sck_i(sck_o), .sel_n_i(sel_n), .mosi_i(mosi_o),
		.tx_word_i(32'h123456F0), .miso_o(miso_i), .rx_word_o(rx_word));
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (rsp_valid_o === 1'b1) begin
			rsp_q <= rsp_data_o;
			rsp_k <= rsp_kind_o;
		end
	end
	// ****
	// bus and operation drivers
	// ****
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk_i);
		address_i <= a;
		writedata_i <= d;
		read_i <= !w;
		write_i <= w;
		do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask
	task automatic cfg(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic op(input sfc_op_t k, input logic [31:0] d, input logic last);
		@(posedge mclk_i);
		op_kind_i <= k;
		op_data_i <= d;
		op_last_i <= last;
		op_valid_i <= 1'b1;
		do @(posedge mclk_i); while (op_ready_o !== 1'b1);
		op_valid_i <= 1'b0;
		do @(posedge mclk_i); while (op_ready_o !== 1'b1);
		repeat (4) @(posedge mclk_i);
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// whole run is near 3000 cycles; this leaves ample margin
	initial begin
		#200us;
		fail_count++;
		end_sim();
	end
	initial begin
		logic [31:0] q;
		repeat (16) @(posedge mclk_i);
		nrst_i <= 1'b1;
		foreach (rows[i]) begin
			bus(rows[i].w, rows[i].a, rows[i].d, q);
			if (rows[i].w) bus(1'b0, rows[i].a, 32'h0, q);
			`CHK("register", rows[i].e, q)
		end
		`CHK("base out", 32'hA55A3CC3, buffer_base_o)
		$display("register table done");
		cfg(SFC_ADDR_BIT_ORDER, 32'h0);
		op(SFC_OP_CMD, 32'h9F, 1'b1);
		`CHK("cmd msb", 8'h9F, rx_word[7:0])
		op(SFC_OP_WDATA, 32'h12345678, 1'b1);
		`CHK("wdata big msb", 32'h12345678, rx_word)
		foreach (modes[i]) begin
			cfg(SFC_ADDR_LINE_CTRL, {16'h0, modes[i][47:32]});
			op(SFC_OP_RDATA, 32'h0, 1'b1);
			`CHK("receive line", modes[i][31:0], rx_word)
			`CHK("rdata big", 32'h123456F0, rsp_q)
		end
		cfg(SFC_ADDR_BIT_ORDER, 32'h103);
		op(SFC_OP_WDATA, 32'h12345678, 1'b1);
		`CHK("wdata little lsb", 32'h1E6A2C48, rx_word)
		op(SFC_OP_CMD, 32'h9F, 1'b1);
		`CHK("cmd lsb", 8'hF9, rx_word[7:0])
		cfg(SFC_ADDR_BIT_ORDER, 32'h5);
		op(SFC_OP_RDATA, 32'h0, 1'b1);
		`CHK("rdata little flipped", 32'h0F6A2C48, rsp_q)
		cfg(SFC_ADDR_BIT_ORDER, 32'h8);
		op(SFC_OP_STATUS, 32'h0, 1'b1);
		`CHK("status flipped", 8'h48, rsp_q[7:0])
		`CHK("status kind", SFC_OP_STATUS, rsp_k)
		$display("frame tests done");
		fifo_state_i <= 3'h5;
		mem_state_i <= 2'h2;
		op(SFC_OP_CMD, 32'h05, 1'b0);
		bus(1'b0, SFC_ADDR_FSM_VIEW, 32'h0, q);
		`CHK("state view held", 32'h0352, q)
		op(SFC_OP_CMD, 32'h00, 1'b1);
		cfg(SFC_ADDR_BYPASS, 32'h1);
		// offer only once the bypass has reached the engine
		repeat (2) @(posedge mclk_i);
		op_valid_i <= 1'b1;
		repeat (20) @(posedge mclk_i);
		`CHK("bypass out", 1'b1, bypass_o)
		`CHK("bypass refuses", 1'b0, op_ready_o)
		op_valid_i <= 1'b0;
		cfg(SFC_ADDR_BYPASS, 32'h0);
		cfg(SFC_ADDR_SUPPLY, 32'h0);
		repeat (2) @(posedge mclk_i);
		`CHK("supply off", 1'b0, flash_supply_en_o)
		$display("view and bypass done");
		nrst_i <= 1'b0;
		repeat (16) @(posedge mclk_i);
		nrst_i <= 1'b1;
		`CHK("base after reset", 32'h0, buffer_base_o)
		`CHK("supply after reset", 1'b1, flash_supply_en_o)
		bus(1'b0, SFC_ADDR_BIT_ORDER, 32'h0, q);
		`CHK("bit order after reset", 32'h103, q)
		$display("second reset done");
		end_sim();
	end
endmodule // tb_sfc_ctrl
bind sfc_ctrl sfc_chk i_sfc_chk (.mclk_i, .nrst_i, .address_i, .read_i, .write_i,
	.writedata_i, .readdata_o, .waitrequest_o, .op_valid_i, .op_kind_i, .op_data_i,
	.op_ready_o, .mosi_o, .flash_supply_en_o, .bypass_o);
